/* hw/pssm_top.sv */
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pssm_top (
    input wire logic mclk, // 40 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [2:0] strap_input_first, // decoded strap value, pin
    input wire logic [2:0] strap_input_second, // decoded strap value, pin
    input wire logic die_temp_hot, // die above shutdown threshold
    input wire logic die_temp_cool, // die below threshold less hysteresis
    input wire logic [1:0] path_temp_hot, // source path sensors above threshold
    input wire logic [1:0] path_temp_cool, // source path sensors cooled by hysteresis
    input wire logic cc_attach_det, // type-c connection detected, pin
    input wire logic act_pd_msg, // incoming pd message
    input wire logic act_cc_change, // cc status change
    input wire logic act_gpio, // gpio input event
    input wire logic act_i2c, // i2c transaction
    input wire logic act_volt_alert, // voltage alert
    input wire logic act_fault_alert, // fault alert
    output logic low_voltage_source_path_en, // 5 V source path enable
    output logic high_voltage_sink_path_en, // internal sink path enable
    output logic external_sink_path_gate_en, // external sink gate enable
    output logic cable_supply_path_en, // cable supply path enable
    output logic cc1_rd_en, // cc1 Rd termination
    output logic cc1_rp_en, // cc1 Rp 3.0 A termination
    output logic cc2_term_en, // cc2 termination, always open
    output logic pd_phy_en, // pd physical layer enable
    output logic normal_run_mode, // running mode entered
    output logic func_en, // functions enabled outside die shutdown
    output logic [1:0] addr_index, // i2c address index, 0 means #1
    output logic eeprom_load_req, // one-cycle pulse: start config load
    output logic irq // level interrupt
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam int SYNC_W = 13;
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    assign pin_raw = {cc_attach_det, path_temp_cool, path_temp_hot, die_temp_cool,
                      die_temp_hot, strap_input_second, strap_input_first};
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    logic [2:0] strap_a;
    logic [2:0] strap_b;
    logic die_hot;
    logic die_cool;
    logic [1:0] path_hot;
    logic [1:0] path_cool;
    logic attach;
    assign strap_a = sync2_q[2:0];
    assign strap_b = sync2_q[5:3];
    assign die_hot = sync2_q[6];
    assign die_cool = sync2_q[7];
    assign path_hot = sync2_q[9:8];
    assign path_cool = sync2_q[11:10];
    assign attach = sync2_q[12];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [pssm_pkg::CTRL_W-1:0] ctrl_q;
    logic [31:0] idle_t_q;
    logic [31:0] sleep_t_q;
    logic [pssm_pkg::IRQ_W-1:0] irq_stat_q;
    logic [pssm_pkg::IRQ_W-1:0] irq_en_q;
    logic [pssm_pkg::IRQ_W-1:0] irq_evt;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [31:0] rd_mux;
    pssm_pkg::pssm_state_e state_q;
    pssm_pkg::pssm_policy_e policy_q;
    logic strap_bad_q;
    logic die_sd_q;
    logic path_sd_q;
    logic sink_q;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign mapped = (paddr == pssm_pkg::OFF_CTRL) || (paddr == pssm_pkg::OFF_IDLE_T)
                 || (paddr == pssm_pkg::OFF_SLEEP_T) || (paddr == pssm_pkg::OFF_STATUS)
                 || (paddr == pssm_pkg::OFF_IRQ_STAT) || (paddr == pssm_pkg::OFF_IRQ_CLR)
                 || (paddr == pssm_pkg::OFF_IRQ_EN);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            pssm_pkg::OFF_CTRL: rd_mux = {25'h0, ctrl_q};
            pssm_pkg::OFF_IDLE_T: rd_mux = idle_t_q;
            pssm_pkg::OFF_SLEEP_T: rd_mux = sleep_t_q;
            pssm_pkg::OFF_STATUS: rd_mux = {20'h0, strap_bad_q, normal_run_mode, pd_phy_en,
                                            sink_q, path_sd_q, die_sd_q, addr_index,
                                            policy_q, state_q};
            pssm_pkg::OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
            pssm_pkg::OFF_IRQ_EN: rd_mux = {28'h0, irq_en_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // no wait state: the answer is prepared during the setup cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // the re-enable bit is a command and never stored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= pssm_pkg::CTRL_RST;
            idle_t_q <= pssm_pkg::IDLE_T_RST;
            sleep_t_q <= pssm_pkg::SLEEP_T_RST;
            irq_en_q <= '0;
        end else if (wr_en) begin
            if (paddr == pssm_pkg::OFF_CTRL) begin
                ctrl_q <= pwdata[pssm_pkg::CTRL_W-1:0] & ~(7'h01 << pssm_pkg::CTRL_PATH_REEN);
            end
            if (paddr == pssm_pkg::OFF_IDLE_T) begin
                idle_t_q <= pwdata;
            end
            if (paddr == pssm_pkg::OFF_SLEEP_T) begin
                sleep_t_q <= pwdata;
            end
            if (paddr == pssm_pkg::OFF_IRQ_EN) begin
                irq_en_q <= pwdata[pssm_pkg::IRQ_W-1:0];
            end
        end
    end

    logic path_reen_cmd;
    assign path_reen_cmd = wr_en && (paddr == pssm_pkg::OFF_CTRL)
                        && pwdata[pssm_pkg::CTRL_PATH_REEN];

    // sticky events; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == pssm_pkg::OFF_IRQ_CLR)
                          ? pwdata[pssm_pkg::IRQ_W-1:0] : '0)) | irq_evt;
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ---------------------------------------------------------------
    // boot: strap capture and configuration request
    // ---------------------------------------------------------------
    logic [1:0] settle_q;
    pssm_pkg::pssm_strap_s dec;
    assign dec = pssm_pkg::pssm_decode(strap_a, strap_b);

    // straps are read only once the synchronisers hold settled pin levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            settle_q <= 2'h0;
            policy_q <= pssm_pkg::PSSM_POL_SAFE;
            addr_index <= 2'h0;
            strap_bad_q <= 1'b0;
            eeprom_load_req <= 1'b0;
        end else begin
            eeprom_load_req <= 1'b0;
            if (state_q == pssm_pkg::PSSM_ST_BOOT) begin
                if (settle_q != pssm_pkg::STRAP_SETTLE_CYC) begin
                    settle_q <= settle_q + 2'h1;
                end else begin
                    // unknown codes fall back to the safest policy
                    policy_q <= dec.policy;
                    addr_index <= dec.idx;
                    strap_bad_q <= !dec.valid;
                    eeprom_load_req <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // power state machine
    // ---------------------------------------------------------------
    pssm_tmr_if tif ();
    pssm_idle_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .tif(tif)
    );

    logic activity;
    logic attach_d_q;
    logic attach_rise;
    logic mstby;
    pssm_pkg::pssm_state_e state_d;
    assign activity = act_pd_msg || act_cc_change || act_gpio || act_i2c
                   || act_volt_alert || act_fault_alert;
    assign attach_rise = attach && !attach_d_q;
    assign mstby = ctrl_q[pssm_pkg::CTRL_MSTBY];
    assign tif.restart = activity || (state_d != state_q);
    assign tif.period = (state_q == pssm_pkg::PSSM_ST_IDLE) ? sleep_t_q : idle_t_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pssm_pkg::PSSM_ST_BOOT: begin
                if (settle_q == pssm_pkg::STRAP_SETTLE_CYC) begin
                    state_d = pssm_pkg::PSSM_ST_ACTIVE;
                end
            end
            pssm_pkg::PSSM_ST_ACTIVE: begin
                if (tif.expired && !activity) begin
                    state_d = pssm_pkg::PSSM_ST_IDLE;
                end
            end
            pssm_pkg::PSSM_ST_IDLE: begin
                if (activity || attach_rise) begin
                    state_d = pssm_pkg::PSSM_ST_ACTIVE;
                end else if (tif.expired && !mstby) begin
                    // standby holds the Idle sub-state instead of sleeping
                    state_d = pssm_pkg::PSSM_ST_SLEEP;
                end
            end
            pssm_pkg::PSSM_ST_SLEEP: begin
                if (attach_rise || activity) begin
                    state_d = pssm_pkg::PSSM_ST_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= pssm_pkg::PSSM_ST_BOOT;
            attach_d_q <= 1'b0;
        end else begin
            state_q <= state_d;
            attach_d_q <= attach;
        end
    end

    // ---------------------------------------------------------------
    // thermal shutdown
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            die_sd_q <= 1'b0;
            path_sd_q <= 1'b0;
        end else begin
            if (die_hot) begin
                die_sd_q <= 1'b1;
            end else if (die_cool) begin
                die_sd_q <= 1'b0;
            end
            // a re-enable written while still hot is ignored
            if (|path_hot) begin
                path_sd_q <= 1'b1;
            end else if (&path_cool && (ctrl_q[pssm_pkg::CTRL_PATH_AUTO] || path_reen_cmd)) begin
                path_sd_q <= 1'b0;
            end
        end
    end

    always_comb begin
        irq_evt = '0;
        irq_evt[pssm_pkg::IRQ_DIE_SD] = die_hot && !die_sd_q;
        irq_evt[pssm_pkg::IRQ_PATH_SD] = (|path_hot) && !path_sd_q;
        irq_evt[pssm_pkg::IRQ_WAKE] = (state_q == pssm_pkg::PSSM_ST_SLEEP)
                                   && (state_d == pssm_pkg::PSSM_ST_ACTIVE);
        irq_evt[pssm_pkg::IRQ_IDLE] = (state_q == pssm_pkg::PSSM_ST_ACTIVE)
                                   && (state_d == pssm_pkg::PSSM_ST_IDLE);
    end

    // ---------------------------------------------------------------
    // power path and termination control
    // ---------------------------------------------------------------
    logic cfg_ok;
    logic run_state;
    logic full_on;
    logic sink_sel;
    logic src_sel;
    logic pd_ok;
    assign cfg_ok = ctrl_q[pssm_pkg::CTRL_CFG_LOADED];
    assign run_state = (state_q == pssm_pkg::PSSM_ST_ACTIVE) || (state_q == pssm_pkg::PSSM_ST_IDLE);
    assign full_on = run_state && !(state_q == pssm_pkg::PSSM_ST_IDLE && mstby);
    // before configuration the dead-battery policy alone picks the sink role;
    // negotiate trusts the system not to pair it with an EEPROM patch
    assign sink_sel = cfg_ok ? (ctrl_q[pssm_pkg::CTRL_SINK_ROLE] && !ctrl_q[pssm_pkg::CTRL_SRC_ONLY])
                             : (policy_q != pssm_pkg::PSSM_POL_SAFE);
    assign src_sel = cfg_ok && !sink_sel;
    assign pd_ok = cfg_ok || (policy_q == pssm_pkg::PSSM_POL_NEGOTIATE);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_voltage_source_path_en <= 1'b0;
            high_voltage_sink_path_en <= 1'b0;
            external_sink_path_gate_en <= 1'b0;
            cable_supply_path_en <= 1'b0;
            cc1_rd_en <= 1'b0;
            cc1_rp_en <= 1'b0;
            cc2_term_en <= 1'b0;
            pd_phy_en <= 1'b0;
            normal_run_mode <= 1'b0;
            func_en <= 1'b0;
            sink_q <= 1'b0;
        end else begin
            func_en <= !die_sd_q;
            sink_q <= !die_sd_q && ((sink_sel && full_on)
                   || (!cfg_ok && policy_q == pssm_pkg::PSSM_POL_SINK_ON && state_q != pssm_pkg::PSSM_ST_BOOT));
            high_voltage_sink_path_en <= sink_q && !ctrl_q[pssm_pkg::CTRL_EXT_GATE];
            external_sink_path_gate_en <= sink_q && ctrl_q[pssm_pkg::CTRL_EXT_GATE];
            low_voltage_source_path_en <= !die_sd_q && !path_sd_q && src_sel && run_state;
            cable_supply_path_en <= !die_sd_q && !path_sd_q && full_on;
            cc1_rd_en <= !die_sd_q && full_on && src_sel;
            cc1_rp_en <= !die_sd_q && full_on && sink_sel;
            cc2_term_en <= 1'b0;
            pd_phy_en <= !die_sd_q && run_state && pd_ok;
            normal_run_mode <= !die_sd_q && run_state && pd_ok;
        end
    end
endmodule

/* hw/pssm_pkg.sv */
package pssm_pkg;

    // ---------------------------------------------------------------
    // register map (byte offsets)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_IDLE_T = 8'h04;
    localparam logic [7:0] OFF_SLEEP_T = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN = 8'h18;

    // control register fields
    localparam int CTRL_CFG_LOADED = 0;
    localparam int CTRL_SINK_ROLE = 1;
    localparam int CTRL_MSTBY = 2;
    localparam int CTRL_PATH_AUTO = 3;
    localparam int CTRL_PATH_REEN = 4;
    localparam int CTRL_EXT_GATE = 5;
    localparam int CTRL_SRC_ONLY = 6;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h08;

    // interrupt bits
    localparam int IRQ_DIE_SD = 0;
    localparam int IRQ_PATH_SD = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_IDLE = 3;
    localparam int IRQ_W = 4;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int IDLE_T_US = 1000;
    localparam int SLEEP_T_US = 10000;
    localparam logic [31:0] IDLE_T_RST = 32'(IDLE_T_US * CLK_MHZ);
    localparam logic [31:0] SLEEP_T_RST = 32'(SLEEP_T_US * CLK_MHZ);
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PSSM_ST_BOOT = 2'b00,
        PSSM_ST_ACTIVE = 2'b01,
        PSSM_ST_IDLE = 2'b10,
        PSSM_ST_SLEEP = 2'b11
    } pssm_state_e;

    typedef enum logic [1:0] {
        PSSM_POL_SAFE = 2'b00,
        PSSM_POL_NEGOTIATE = 2'b01,
        PSSM_POL_SINK_ON = 2'b10
    } pssm_policy_e;

    typedef struct packed {
        logic valid;
        pssm_policy_e policy;
        logic [1:0] idx;
    } pssm_strap_s;

    // decoded strap pair -> address index (0..3 means #1..#4) and policy
    function automatic pssm_strap_s pssm_decode(input logic [2:0] a, input logic [2:0] b);
        pssm_strap_s r;
        r = '{valid: 1'b1, policy: PSSM_POL_SAFE, idx: 2'h0};
        unique case ({a, b})
            6'o73: r = '{1'b1, PSSM_POL_NEGOTIATE, 2'h0};
            6'o33: r = '{1'b1, PSSM_POL_NEGOTIATE, 2'h1};
            6'o40: r = '{1'b1, PSSM_POL_NEGOTIATE, 2'h2};
            6'o37: r = '{1'b1, PSSM_POL_NEGOTIATE, 2'h3};
            6'o70: r = '{1'b1, PSSM_POL_SAFE, 2'h0};
            6'o00: r = '{1'b1, PSSM_POL_SAFE, 2'h1};
            6'o60: r = '{1'b1, PSSM_POL_SAFE, 2'h2};
            6'o57: r = '{1'b1, PSSM_POL_SAFE, 2'h3};
            6'o75: r = '{1'b1, PSSM_POL_SINK_ON, 2'h0};
            6'o55: r = '{1'b1, PSSM_POL_SINK_ON, 2'h1};
            6'o20: r = '{1'b1, PSSM_POL_SINK_ON, 2'h2};
            6'o17: r = '{1'b1, PSSM_POL_SINK_ON, 2'h3};
            default: r = '{1'b0, PSSM_POL_SAFE, 2'h0};
        endcase
        return r;
    endfunction

endpackage

/* hw/pssm_tmr_if.sv */
`timescale 1ns/1ps
interface pssm_tmr_if;
    logic restart;
    logic [31:0] period;
    logic expired;
    modport ctl (output restart, output period, input expired);
    modport tmr (input restart, input period, output expired);
endinterface

/* hw/pssm_idle_timer.sv */
`timescale 1ns/1ps
module pssm_idle_timer (
    input wire logic mclk, // system clock
    input wire logic rst, // async reset, active high
    pssm_tmr_if.tmr tif // restart, period and expiry
);
    logic [31:0] count_q;

    // counts quiet cycles and saturates at the period; expiry is a level, so a move
    // held back by standby is taken once the hold lifts
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= 32'h0000_0000;
        end else if (tif.restart) begin
            count_q <= 32'h0000_0000;
        end else if (count_q < tif.period) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // a period of zero never expires, which parks the state machine
    assign tif.expired = (tif.period != 32'h0000_0000)
                         && (count_q >= tif.period - 32'h0000_0001);
endmodule

/* dv/pssm_monitor.sv */
`timescale 1ns/1ps
module pssm_monitor (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic die_temp_hot, // die hot
    input wire logic [1:0] path_temp_hot, // path hot
    input wire logic low_voltage_source_path_en, // source
    input wire logic cable_supply_path_en, // cable
    input wire logic cc1_rd_en, // cc1 rd
    input wire logic cc1_rp_en, // cc1 rp
    input wire logic cc2_term_en, // cc2
    input wire logic func_en, // functions
    input wire logic [1:0] addr_index, // index
    input wire logic eeprom_load_req // load
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    cc2_open_a: assert property (!cc2_term_en)
        else $error("cc2 terminated");
    cc1_single_a: assert property (!(cc1_rd_en && cc1_rp_en))
        else $error("cc1 rd with rp");
    // eight cycles covers the sync stages and the output register
    die_off_a: assert property (
        die_temp_hot [*8] |-> !func_en && !cable_supply_path_en) else $error("die hot, on");
    path_off_a: assert property (
        (path_temp_hot != 2'h0) [*8] |-> !low_voltage_source_path_en && !cable_supply_path_en)
        else $error("path hot, on");
    load_pulse_a: assert property (eeprom_load_req |=> !eeprom_load_req)
        else $error("load request long");
    index_hold_a: assert property (eeprom_load_req |=> $stable(addr_index) [*8])
        else $error("index moved");
    ready_time_a: assert property (psel && !penable |=> pready)
        else $error("no ready");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule

bind pssm_top pssm_monitor mon (.mclk, .rst, .psel, .penable, .pready, .pslverr,
    .die_temp_hot, .path_temp_hot, .low_voltage_source_path_en, .cable_supply_path_en,
    .cc1_rd_en, .cc1_rp_en, .cc2_term_en, .func_en, .addr_index, .eeprom_load_req);

/* dv/pssm_port_partner.sv */
`timescale 1ns/1ps
module pssm_port_partner (
    input wire logic mclk, // clock
    input wire logic attach, // plug-in request
    output logic cc_attach_det = 1'b0, // attach level
    output logic act_cc_change = 1'b0, // cc change pulse
    output logic act_pd_msg = 1'b0 // first pd message
);
    logic [3:0] wait_q = 4'h0;
    // a real source needs time to advertise, so the message trails the attach
    always @(posedge mclk) begin
        cc_attach_det <= attach;
        act_cc_change <= attach ^ cc_attach_det;
        wait_q <= (attach && !cc_attach_det) ? 4'h6 : wait_q - 4'(wait_q != 4'h0);
        act_pd_msg <= (wait_q == 4'h1);
    end
endmodule

/* dv/tb_power_state_and_strap_manager.sv */
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) miss(32'(g), 32'(x)); end
module tb_power_state_and_strap_manager;
    localparam logic [5:0] CODES [12] = '{6'h3B, 6'h1B, 6'h20, 6'h1F, 6'h38, 6'h00, 6'h30,
        6'h2F, 6'h3D, 6'h2D, 6'h10, 6'h0F};
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, attach = 1'b0;
    logic die_temp_hot = 1'b0, die_temp_cool = 1'b1, act_gpio = 1'b0, act_i2c = 1'b0;
    logic act_volt_alert = 1'b0, act_fault_alert = 1'b0, pready, pslverr, err, irq, func_en;
    logic cc_attach_det, act_pd_msg, act_cc_change, pd_phy_en, normal_run_mode, eeprom_load_req;
    logic low_voltage_source_path_en, high_voltage_sink_path_en, external_sink_path_gate_en;
    logic cable_supply_path_en, cc1_rd_en, cc1_rp_en, cc2_term_en;
    logic [1:0] path_temp_hot = 2'h0, path_temp_cool = 2'h3, addr_index;
    logic [2:0] strap_input_first = 3'h0, strap_input_second = 3'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] e;
    int failures = 0, checks = 0, seed = 95, n;
    wire logic [5:0] paths = {low_voltage_source_path_en, high_voltage_sink_path_en,
        external_sink_path_gate_en, cable_supply_path_en, cc1_rd_en, cc1_rp_en};
    pssm_top uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .strap_input_first, .strap_input_second, .die_temp_hot, .die_temp_cool,
        .path_temp_hot, .path_temp_cool, .cc_attach_det, .act_pd_msg, .act_cc_change, .act_gpio,
        .act_i2c, .act_volt_alert, .act_fault_alert, .low_voltage_source_path_en,
        .high_voltage_sink_path_en, .external_sink_path_gate_en, .cable_supply_path_en,
        .cc1_rd_en, .cc1_rp_en, .cc2_term_en, .pd_phy_en, .normal_run_mode, .func_en,
        .addr_index, .eeprom_load_req, .irq);
    pssm_port_partner partner (.mclk, .attach, .cc_attach_det, .act_cc_change, .act_pd_msg);
    initial forever #12.5 mclk = ~mclk;
    task automatic miss(input logic [31:0] g, input logic [31:0] x);
        failures++;
        $display("[FAIL] %0t got %h expected %h", $time, g, x);
    endtask
    task automatic close_out;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bound(input int k);
        if (k >= 40) begin
            miss(32'h0, 32'h1);
            close_out();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        bound(k);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic boot(input logic [5:0] code);
        int k;
        k = 0;
        {strap_input_first, strap_input_second} <= code;
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        do begin
            @(posedge mclk);
            k++;
        end while (eeprom_load_req !== 1'b1 && k < 40);
        bound(k);
        repeat (3) @(posedge mclk);
    endtask
    task automatic st(input logic [1:0] s, input logic [5:0] p);
        apb(1'b0, pssm_pkg::OFF_STATUS, 32'h0);
        `CHK(rd[1:0], s)
        `CHK(paths, p)
    endtask
    // {invalid, policy, index}; an unknown pair falls back to safe at index #1
    function automatic logic [4:0] exp_dec(input logic [5:0] code);
        exp_dec = 5'h10;
        for (int i = 0; i < 12; i++)
            if (CODES[i] == code)
                exp_dec = {1'b0, (i < 4) ? 2'h1 : (i < 8) ? 2'h0 : 2'h2, 2'(i % 4)};
    endfunction
    initial begin
        for (int i = 0; i < 14; i++) begin
            e = exp_dec((i < 12) ? CODES[i] : 6'($random(seed)));
            boot((i < 12) ? CODES[i] : 6'($random(seed)));
            if (i >= 12)
                e = exp_dec({strap_input_first, strap_input_second});
            `CHK(addr_index, e[1:0])
            apb(1'b0, pssm_pkg::OFF_STATUS, 32'h0);
            `CHK({rd[11], rd[3:2], rd[5:4]}, e)
            `CHK(paths, (e[3:2] != 2'h0) ? 6'h15 : 6'h04)
            `CHK({pd_phy_en, normal_run_mode}, {2{e[3:2] == 2'h1}})
        end
        boot(6'h00); // safe straps, as a system patched from eeprom must use
        apb(1'b1, pssm_pkg::OFF_CTRL, 32'h9);
        apb(1'b1, pssm_pkg::OFF_IRQ_EN, 32'hF);
        apb(1'b1, pssm_pkg::OFF_SLEEP_T, 32'h1E);
        apb(1'b1, pssm_pkg::OFF_IDLE_T, 32'h14);
        repeat (60) begin
            @(posedge mclk);
            {act_gpio, act_i2c, act_volt_alert, act_fault_alert} <= 4'($random(seed));
        end
        @(posedge mclk);
        {act_gpio, act_i2c, act_volt_alert, act_fault_alert} <= 4'h0;
        st(2'h1, 6'h26);
        repeat (28) @(posedge mclk);
        st(2'h2, 6'h26);
        apb(1'b0, pssm_pkg::OFF_IRQ_STAT, 32'h0);
        `CHK({rd[3], irq}, 2'h3)
        apb(1'b1, pssm_pkg::OFF_CTRL, 32'hD);
        repeat (60) @(posedge mclk);
        st(2'h2, 6'h20);
        apb(1'b1, pssm_pkg::OFF_IRQ_CLR, 32'hF);
        apb(1'b1, pssm_pkg::OFF_IRQ_EN, 32'h3);
        apb(1'b1, pssm_pkg::OFF_IDLE_T, 32'h0);
        apb(1'b1, pssm_pkg::OFF_CTRL, 32'h9);
        apb(1'b0, pssm_pkg::OFF_IRQ_STAT, 32'h0);
        `CHK({rd[3:0], irq}, 5'h0)
        repeat (40) @(posedge mclk);
        st(2'h3, 6'h00);
        attach <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (low_voltage_source_path_en !== 1'b1 && n < 40);
        bound(n);
        st(2'h1, 6'h26);
        apb(1'b0, pssm_pkg::OFF_IRQ_STAT, 32'h0);
        `CHK({rd[2], irq}, 2'h2)
        apb(1'b1, pssm_pkg::OFF_IRQ_EN, 32'hF);
        @(posedge mclk);
        `CHK(irq, 1'b1)
        die_temp_hot <= 1'b1;
        die_temp_cool <= 1'b0;
        repeat (10) @(posedge mclk);
        `CHK({func_en, paths}, 7'h00)
        die_temp_hot <= 1'b0;
        die_temp_cool <= 1'b1;
        repeat (10) @(posedge mclk);
        `CHK({func_en, paths}, 7'h66)
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, pssm_pkg::OFF_CTRL, k ? 32'h1 : 32'h9);
            path_temp_hot <= 2'(1 << k);
            path_temp_cool <= 2'h0;
            repeat (8) @(posedge mclk);
            `CHK({low_voltage_source_path_en, cable_supply_path_en}, 2'h0)
            path_temp_hot <= 2'h0;
            path_temp_cool <= 2'h3;
            repeat (8) @(posedge mclk);
            `CHK(low_voltage_source_path_en, k == 0)
        end
        apb(1'b1, pssm_pkg::OFF_CTRL, 32'h11);
        repeat (3) @(posedge mclk);
        `CHK(low_voltage_source_path_en, 1'b1)
        apb(1'b0, pssm_pkg::OFF_IRQ_STAT, 32'h0);
        `CHK(rd[1:0], 2'h3)
        apb(1'b1, pssm_pkg::OFF_CTRL, 32'h23);
        repeat (3) @(posedge mclk);
        `CHK(paths, 6'h0D)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        close_out();
    end
endmodule
